// file: common/dsr_pkg.sv
// Purpose: Shared constants and types for the DDR SRAM read/address link
// Assumes: One system clock; link clocks are levels made by the controller
// Notes:   The x18 organization is built; other widths kept for reference
package dsr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Organization
    localparam int ADDR_W_X8   = 21;                            // [RULE_03]
    localparam int ADDR_W_X9   = 21;                            // [RULE_03]
    localparam int ADDR_W_X18  = 20;                            // [RULE_03]
    localparam int ADDR_W_X36  = 19;                            // [RULE_03]
    localparam int ADDR_W      = ADDR_W_X18;
    localparam int WORD_W      = 18;
    localparam int BURST_LEN   = 2;
    localparam int ARRAY_DEPTH = 1 << ADDR_W;
    localparam int PAIR_W      = WORD_W * BURST_LEN;

    ////////////////////////////////////////////////////////////////////////
    // Buffering and reset values
    localparam int FIFO_DEPTH = 4;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
    localparam logic [WORD_W-1:0] WORD_RST  = 18'h00000;

    ////////////////////////////////////////////////////////////////////////
    // Read output sequencer
    typedef enum logic [2:0] {
        DSR_ST_IDLE  = 3'b001,
        DSR_ST_WORD0 = 3'b010,
        DSR_ST_WORD1 = 3'b100
    } dsr_out_state_t;

endpackage : dsr_pkg

// file: common/dsr_link_if.sv
// Purpose: Board-level link between controller and SRAM read/address port
// Assumes: All signals change on the rising edge of the system clock
// Notes:   q_oe high means the device drives q; q is undefined otherwise
interface dsr_link_if
(
    input wire logic clk
);
    import dsr_pkg::*;

    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic [ADDR_W-1:0] addr;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic [WORD_W-1:0] q;
    logic              q_oe;

    modport dev
    (
        input  k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
        output q, q_oe
    );

    modport ctl
    (
        output k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
        input  q, q_oe
    );

endinterface : dsr_link_if

// file: src/dsr_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty from pointers with a wrap bit
module dsr_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import dsr_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wptr_q;
    logic [PW:0]      rptr_q;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Flags
    assign in_ready  = (wptr_q[PW-1:0] != rptr_q[PW-1:0]) || (wptr_q[PW] == rptr_q[PW]);
    assign out_valid = (wptr_q != rptr_q);
    assign out_data  = mem_q[rptr_q[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////////////
    // Storage and pointers
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wptr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop)
            begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

endmodule : dsr_fifo

// file: src/dsr_sram_dev.sv
// Purpose: SRAM end: address capture, read port select and DDR read output
// Assumes: Link clocks are levels sampled on clk; a high level after a low sample is a rising edge
// Notes:   Array is filled through the load port; write data is not modelled
//
// Overview of operation
// [RULE_01] Read address on K rise, write on K#
// [RULE_02] Controller time-shares one address bus
// [RULE_03] Address width set by word organization
// [RULE_04] Address ignored when its port is deselected
// [RULE_05] Read data launched on C and C# rises
// [RULE_06] Single clock mode launches on K and K#
// [RULE_07] Deselected read port tri-states the outputs
// [RULE_08] Read select active low, sampled on K
// [RULE_09] Finish pending read, then release after C
// [RULE_10] Each read returns two sequential words
// [RULE_11] All accesses begin on K rise; writes here begin on K# rise
// [RULE_12] Inputs also captured on K# rise
// [RULE_13] Controller supplies the output clock pair
// [RULE_14] Word zero on C, word one on C#
// [RULE_15] Controller may issue one read per cycle; this controller keeps one read in flight at a time
module dsr_sram_dev (
    input  wire logic                       clk,
    input  wire logic                       rst,
    dsr_link_if.dev                         link,
    input  wire logic                       single_clock_mode,
    input  wire logic                       load_we,
    input  wire logic                       load_bank,
    input  wire logic [dsr_pkg::ADDR_W-1:0] load_addr,
    input  wire logic [dsr_pkg::WORD_W-1:0] load_data,
    output logic      [dsr_pkg::ADDR_W-1:0] wr_addr,
    output logic                            wr_addr_valid
);
    import dsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [WORD_W-1:0] array_q [BURST_LEN][ARRAY_DEPTH];               // [RULE_03]
    logic              k_prev_q;
    logic              k_n_prev_q;
    logic              c_prev_q;
    logic              c_n_prev_q;
    logic              k_rise;
    logic              k_n_rise;
    logic              c_rise;
    logic              c_n_rise;
    logic              out_pos;
    logic              out_neg;
    logic              pend_q;
    logic [ADDR_W-1:0] pend_addr_q;
    logic [ADDR_W-1:0] burst_addr_q;
    logic [WORD_W-1:0] q_q;
    logic              q_oe_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              wr_addr_valid_q;
    dsr_out_state_t    state_q;

    ////////////////////////////////////////////////////////////////////////
    // Memory arrays, one per burst word
    generate
        for (genvar b = 0; b < BURST_LEN; b++)
        begin : g_bank
            always_ff @(posedge clk)
            begin
                if (load_we && (load_bank == 1'(b)))
                begin
                    array_q[b][load_addr] <= load_data;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Link clock edge detection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            k_prev_q   <= 1'b0;
            k_n_prev_q <= 1'b1;
            c_prev_q   <= 1'b0;
            c_n_prev_q <= 1'b1;
        end
        else
        begin
            k_prev_q   <= link.k;
            k_n_prev_q <= link.k_n;
            c_prev_q   <= link.c;
            c_n_prev_q <= link.c_n;
        end
    end

    assign k_rise   = link.k   && !k_prev_q;
    assign k_n_rise = link.k_n && !k_n_prev_q;
    assign c_rise   = link.c   && !c_prev_q;
    assign c_n_rise = link.c_n && !c_n_prev_q;

    // Output launch edges
    assign out_pos = single_clock_mode ? k_rise   : c_rise;             // [RULE_06]
    assign out_neg = single_clock_mode ? k_n_rise : c_n_rise;           // [RULE_05]

    ////////////////////////////////////////////////////////////////////////
    // Read request capture on K
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_q      <= 1'b0;
            pend_addr_q <= ADDR_RST;
        end
        else if (k_rise && !link.read_port_select_n)                    // [RULE_08] [RULE_04]
        begin
            pend_q      <= 1'b1;                                        // [RULE_11]
            pend_addr_q <= link.addr;                                   // [RULE_01]
        end
        else if (out_pos)
        begin
            pend_q      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write address capture on K#
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_addr_q       <= ADDR_RST;
            wr_addr_valid_q <= 1'b0;
        end
        else
        begin
            wr_addr_valid_q <= 1'b0;
            if (k_n_rise && !link.write_port_select_n)                  // [RULE_12] [RULE_04]
            begin
                wr_addr_q       <= link.addr;                           // [RULE_01]
                wr_addr_valid_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read burst sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q      <= DSR_ST_IDLE;
            burst_addr_q <= ADDR_RST;
        end
        else if (out_pos)
        begin
            if (pend_q)
            begin
                state_q      <= DSR_ST_WORD0;                           // [RULE_10]
                burst_addr_q <= pend_addr_q;
            end
            else
            begin
                state_q      <= DSR_ST_IDLE;                            // [RULE_09]
            end
        end
        else if (out_neg)
        begin
            unique case (state_q)
                DSR_ST_IDLE:  state_q <= DSR_ST_IDLE;
                DSR_ST_WORD0: state_q <= DSR_ST_WORD1;                  // [RULE_10]
                DSR_ST_WORD1: state_q <= DSR_ST_WORD1;
                default:      state_q <= DSR_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output data and drive enable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_q    <= WORD_RST;
            q_oe_q <= 1'b0;                                             // [RULE_07]
        end
        else if (out_pos)
        begin
            if (pend_q)
            begin
                q_q    <= array_q[0][pend_addr_q];                      // [RULE_14]
                q_oe_q <= 1'b1;                                         // [RULE_05]
            end
            else
            begin
                q_oe_q <= 1'b0;                                         // [RULE_07]
            end
        end
        else if (out_neg && (state_q == DSR_ST_WORD0))
        begin
            q_q <= array_q[1][burst_addr_q];                            // [RULE_14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.q        = q_q;
    assign link.q_oe     = q_oe_q;
    assign wr_addr       = wr_addr_q;
    assign wr_addr_valid = wr_addr_valid_q;

endmodule : dsr_sram_dev

// file: src/dsr_mem_ctl.sv
// Purpose: Controller end: makes link clocks, issues reads and writes
// Assumes: Same clk as the SRAM end; user holds a request until acknowledged
// Notes:   One read in flight at a time; FIFO space reserved before issue
module dsr_mem_ctl (
    input  wire logic                       clk,
    input  wire logic                       rst,
    dsr_link_if.ctl                         link,
    input  wire logic                       single_clock_mode,
    input  wire logic                       rd_req,
    input  wire logic [dsr_pkg::ADDR_W-1:0] rd_addr,
    output logic                            rd_ack,
    input  wire logic                       wr_req,
    input  wire logic [dsr_pkg::ADDR_W-1:0] wr_addr,
    output logic                            wr_ack,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic      [dsr_pkg::PAIR_W-1:0] out_data
);
    import dsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic              k_q;
    logic              k_n_q;
    logic              c_q;
    logic              c_n_q;
    logic [ADDR_W-1:0] addr_q;
    logic              rd_sel_n_q;
    logic              wr_sel_n_q;
    logic              rd_ack_q;
    logic              wr_ack_q;
    logic              lp_q;
    logic              ln_q;
    logic              outst_q;
    logic              have0_q;
    logic [WORD_W-1:0] word0_q;
    logic              push_q;
    logic [PAIR_W-1:0] push_data_q;
    logic              fifo_in_ready;
    logic              can_issue;

    ////////////////////////////////////////////////////////////////////////
    // Link clocks; C pair lags K pair by half a period
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            k_q   <= 1'b0;
            k_n_q <= 1'b1;
            c_q   <= 1'b0;
            c_n_q <= 1'b1;
        end
        else
        begin
            k_q   <= ~k_q;
            k_n_q <= k_q;
            c_q   <= k_q;                                               // [RULE_13]
            c_n_q <= k_n_q;                                             // [RULE_13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address bus and port selects
    assign can_issue = fifo_in_ready && !outst_q && !push_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            addr_q     <= ADDR_RST;
            rd_sel_n_q <= 1'b1;
            wr_sel_n_q <= 1'b1;
            rd_ack_q   <= 1'b0;
            wr_ack_q   <= 1'b0;
        end
        else
        begin
            rd_ack_q   <= 1'b0;
            wr_ack_q   <= 1'b0;
            rd_sel_n_q <= 1'b1;
            wr_sel_n_q <= 1'b1;
            if (!k_q)
            begin
                if (rd_req && can_issue)
                begin
                    rd_sel_n_q <= 1'b0;                                 // [RULE_08]
                    addr_q     <= rd_addr;                              // [RULE_02]
                    rd_ack_q   <= 1'b1;
                end
            end
            else if (wr_req)
            begin
                wr_sel_n_q <= 1'b0;
                addr_q   <= wr_addr;                                    // [RULE_02]
                wr_ack_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data capture, both words per burst
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lp_q        <= 1'b0;
            ln_q        <= 1'b0;
            outst_q     <= 1'b0;
            have0_q     <= 1'b0;
            word0_q     <= WORD_RST;
            push_q      <= 1'b0;
            push_data_q <= '0;
        end
        else
        begin
            lp_q   <= single_clock_mode ? k_q   : c_q;
            ln_q   <= single_clock_mode ? k_n_q : c_n_q;
            push_q <= 1'b0;
            if (!k_q && rd_req && can_issue)
            begin
                outst_q <= 1'b1;
            end
            else if (push_q)
            begin
                outst_q <= 1'b0;
            end
            if (lp_q && link.q_oe)
            begin
                word0_q <= link.q;
                have0_q <= 1'b1;
            end
            else if (ln_q && link.q_oe && have0_q)
            begin
                push_q      <= 1'b1;                                    // [RULE_10]
                push_data_q <= {link.q, word0_q};
                have0_q     <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer
    dsr_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_q),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    assign link.k                   = k_q;
    assign link.k_n                 = k_n_q;
    assign link.c                   = c_q;
    assign link.c_n                 = c_n_q;
    assign link.addr                = addr_q;
    assign link.read_port_select_n  = rd_sel_n_q;
    assign link.write_port_select_n = wr_sel_n_q;
    assign rd_ack                   = rd_ack_q;
    assign wr_ack                   = wr_ack_q;

endmodule : dsr_mem_ctl

// file: sim/dsr_link_assertions.sv
// Purpose: Checks on the controller/SRAM link signals
// Assumes: One clock, synchronous active-high reset
// Notes:   Instantiated beside the link interface, no bind
module dsr_link_assertions
    import dsr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              k,
    input wire logic              k_n,
    input wire logic              c,
    input wire logic              c_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              read_port_select_n,
    input wire logic              write_port_select_n,
    input wire logic [WORD_W-1:0] q,
    input wire logic              q_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Clock pairs
    a_kn_inverse:
        assert property (k_n == !k) else $error("k_n not inverse of k");
    a_k_toggle:
        assert property (!$past(rst) |-> k != $past(k)) else $error("k did not toggle");
    a_c_pair:
        assert property (!$past(rst) |-> c == k_n && c_n == k) else $error("c pair not tied to k pair");

    ////////////////////////////////////////////////////////////////////////
    // Read port
    a_rdsel_in_k:
        assert property (!read_port_select_n |-> k) else $error("read select outside k cycle");
    a_read_launch:
        assert property (k && !read_port_select_n |-> ##[2:3] q_oe) else $error("read data not driven");
    a_burst_two:
        assert property ($rose(q_oe) |=> q_oe) else $error("burst shorter than two words");
    a_release_idle:
        assert property (read_port_select_n [*8] |-> !q_oe) else $error("q not released when idle");
    a_reset_idle:
        assert property (disable iff (1'b0) rst |=> !q_oe && read_port_select_n && write_port_select_n && !k)
        else $error("link not idle after reset");

    ////////////////////////////////////////////////////////////////////////
    // Coverage
    c_read: cover property (k && !read_port_select_n);
    c_write: cover property (k_n && !write_port_select_n);
    c_burst: cover property ($rose(q_oe) ##1 q_oe ##1 !q_oe);
endmodule : dsr_link_assertions

// file: sim/ddr_sram_read_addr_port_test.sv
// Purpose: Self-checking bench of controller end and SRAM end
// Assumes: Both ends share clk; 25 MHz clock
// Notes:   Random addresses from xorshift seeded with 89
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: %s", $time, m); end end
module ddr_sram_read_addr_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dsr_pkg::*;

    logic clk = 1'b0, rst, mode, stall, load_we, load_bank, rd_req, rd_ack, wr_req, wr_ack;
    logic out_valid, out_ready, dev_wr_addr_valid;
    logic [ADDR_W-1:0] load_addr, rd_addr, wr_addr, dev_wr_addr;
    logic [WORD_W-1:0] load_data;
    logic [PAIR_W-1:0] out_data;
    logic [PAIR_W-1:0] exp_q[$];
    logic [ADDR_W-1:0] wr_q[$], addrs[8];
    logic [31:0] seed = 32'h00000059;
    int miscompares = 0, checked = 0, cycles = 0;
    bit got;

    always #20 clk = ~clk;

    dsr_link_if link_bus (.clk(clk));
    dsr_sram_dev u_dsr_sram_dev (.clk(clk), .rst(rst), .link(link_bus), .single_clock_mode(mode),
        .load_we(load_we), .load_bank(load_bank), .load_addr(load_addr), .load_data(load_data),
        .wr_addr(dev_wr_addr), .wr_addr_valid(dev_wr_addr_valid));
    dsr_mem_ctl u_dsr_mem_ctl (.clk(clk), .rst(rst), .link(link_bus), .single_clock_mode(mode),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_ack(wr_ack), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    dsr_link_assertions u_chk (.clk(clk), .rst(rst), .k(link_bus.k), .k_n(link_bus.k_n), .c(link_bus.c),
        .c_n(link_bus.c_n), .addr(link_bus.addr), .read_port_select_n(link_bus.read_port_select_n),
        .write_port_select_n(link_bus.write_port_select_n), .q(link_bus.q), .q_oe(link_bus.q_oe));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [WORD_W-1:0] pat(input logic [ADDR_W-1:0] a, input logic b);
        return a[WORD_W-1:0] ^ {a[19:18], 16'h0000} ^ (b ? 18'h2D2D2 : 18'h1B1B1);
    endfunction : pat

    task automatic final_report();
        $display("counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic do_reset(input logic m);
        rst  <= 1'b1;
        mode <= m;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic do_load(input logic [ADDR_W-1:0] a);
        for (int b = 0; b < 2; b++)
        begin
            load_we   <= 1'b1;
            load_bank <= b[0];
            load_addr <= a;
            load_data <= pat(a, b[0]);
            @(posedge clk);
        end
    endtask : do_load

    task automatic do_read(input logic [ADDR_W-1:0] a, input int lim, output bit ok);
        int n;
        n = 0;
        rd_req  <= 1'b1;
        rd_addr <= a;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rd_ack !== 1'b1 && n < lim);
        ok = (rd_ack === 1'b1);
        if (ok)
            exp_q.push_back({pat(a, 1'b1), pat(a, 1'b0)});
        rd_req <= 1'b0;
        @(posedge clk);
    endtask : do_read

    task automatic do_write(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        wr_req  <= 1'b1;
        wr_addr <= a;
        wr_q.push_back(a);
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wr_ack !== 1'b1 && n < 40);
        `CHK(wr_ack, 1'b1, "write not acknowledged")
        wr_req <= 1'b0;
        @(posedge clk);
    endtask : do_write

    ////////////////////////////////////////////////////////////////////////
    // Monitors and timeout
    always @(posedge clk)
    begin
        out_ready <= stall ? 1'b0 : rnd() % 4 != 0;
        cycles++;
        if (cycles > 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    always @(posedge clk)
    begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b0, 1'b1, "unexpected read data")
            else
                `CHK(out_data, exp_q.pop_front(), "read burst data")
        end
        if (!rst && dev_wr_addr_valid === 1'b1)
        begin
            if (wr_q.size() == 0)
                `CHK(1'b0, 1'b1, "address taken while deselected")
            else
                `CHK(dev_wr_addr, wr_q.pop_front(), "write address")
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {rst, mode, stall, load_we, load_bank, rd_req, wr_req} <= 7'h00;
        {load_addr, rd_addr, wr_addr, load_data} <= '0;
        rst <= 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            do_reset(m[0]);
            addrs[0] = 20'h00000;
            addrs[1] = 20'hFFFFF;
            for (int i = 2; i < 8; i++)
                addrs[i] = rnd() % ARRAY_DEPTH;
            foreach (addrs[i])
                do_load(addrs[i]);
            load_we <= 1'b0;
            foreach (addrs[i])
            begin
                do_read(addrs[i], 40, got);
                `CHK(got, 1'b1, "read refused")
            end
            $display("test reads mode %0d done", m);
            do_write(20'hFFFFF);
            for (int i = 0; i < 3; i++)
                do_write(rnd() % ARRAY_DEPTH);
            $display("test writes mode %0d done", m);
            stall <= 1'b1;
            for (int i = 0; i < 4; i++)
                do_read(addrs[7 - i], 40, got);
            do_read(addrs[0], 30, got);
            `CHK(got, 1'b0, "read taken with full buffer")
            stall <= 1'b0;
            do_read(addrs[0], 60, got);
            `CHK(got, 1'b1, "read lost after drain")
            for (int n = 0; n < 200 && (exp_q.size() + wr_q.size()) != 0; n++)
                @(posedge clk);
            `CHK(exp_q.size() + wr_q.size(), 0, "transfers outstanding")
            $display("test fill mode %0d done", m);
        end
        final_report();
    end
endmodule : ddr_sram_read_addr_port_test
